// ===== inc/pirp_cfg.svh
/*
  Constants of the paged two-wire register port: offsets, field values,
  reset values and timing. Assumes inclusion by bare name.
*/
`ifndef PIRP_CFG_SVH
`define PIRP_CFG_SVH
// Target address upper bits and strap-selected lower bits
`define PIRP_ADDR_HI      3'h5
`define PIRP_LO_GND       4'h0
`define PIRP_LO_VCC       4'hF
`define PIRP_LO_SCL       4'h5
`define PIRP_LO_SDA       4'hA
// Strap pin codes seen on strap_code
`define PIRP_STRAP_GND    2'h0
`define PIRP_STRAP_VCC    2'h1
`define PIRP_STRAP_SCL    2'h2
`define PIRP_STRAP_SDA    2'h3
// Device register offsets
`define PIRP_OFF_MASK     8'hF0
`define PIRP_OFF_STATUS   8'hF1
`define PIRP_OFF_PAGE     8'hFD
`define PIRP_OFF_KEY      8'hFE
// Readable windows of paged space
`define PIRP_P0_LO_A      8'h18
`define PIRP_P0_HI_A      8'h2D
`define PIRP_P0_LO_B      8'h30
`define PIRP_P0_HI_B      8'h45
`define PIRP_P3_RD        8'h11
`define PIRP_PAGE_LED     8'h00
`define PIRP_PAGE_FUNC    8'h03
// Key value and reset values
`define PIRP_KEY_OPEN     8'hC5
`define PIRP_KEY_RST      8'h00
`define PIRP_PAGE_RST     8'h00
`define PIRP_MASK_RST     8'h00
// Host command port offsets and command bits
`define PIRP_H_TGT        3'h0
`define PIRP_H_REG        3'h1
`define PIRP_H_WDATA      3'h2
`define PIRP_H_CMD        3'h3
`define PIRP_H_RDATA      3'h4
`define PIRP_CMD_WR       0
`define PIRP_CMD_RD       1
`define PIRP_H_TGT_RST    7'h50
// Timing: system clock period and serial clock period
`define PIRP_CLK_NS       8
`define PIRP_SCL_NS       2500
`endif

// ===== inc/pirp_pkg.sv
/*
  Types of the paged two-wire register port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pirp_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} pirp_dst_t;
  typedef enum logic [1:0] {BK_ADDR, BK_REG, BK_DATA} pirp_kind_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} pirp_hst_t;
endpackage : pirp_pkg
`default_nettype wire

// ===== inc/pirp_if.sv
/*
  Two-wire bus between host end and device end.
  Assumes both ends only pull the data line low; pull-up is modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
interface pirp_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  wire  sda;
  // Wired-and data line with pull-up
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_oe);
endinterface : pirp_if
`default_nettype wire

// ===== rtl/pirp_sync.sv
/*
  Two-flop synchroniser for pin inputs.
  Assumes one clock; reset value set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module pirp_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pirp_sync
`default_nettype wire

// ===== rtl/pirp_dev.sv
/*
  Device end of the paged two-wire register port: target address match,
  START/STOP, acknowledge, pointer auto increment, reads with repeated
  start, locked page select with one-shot key, interrupt mask/status.
  Assumes the page contents live outside and answer page_rd_data
  combinationally from page_sel_r and reg_ptr_r.
*/
// What this block does
// R1: address byte LSB: 0 write, 1 read
// R2: address 101 plus strap bits 0000/1111
// R3: strap on clock 0101, on data 1010
// R4: data fall, clock high: START, compare address
// R5: data rise, clock high: STOP ends transfer
// R6: eight bits MSB first, sampled clock high
// R7: pull data low during address acknowledge
// R8: master stops on missing address acknowledge
// R9: second written byte is register address, acknowledged
// R10: acknowledge and store each data byte
// R11: pointer increments each acknowledged data byte
// R12: only listed registers return read data
// R13: read: write address, restart, read data
// R14: master selects page 0/3 before reading
// R15: page select values 0-3, others reserved
// R16: page select resets to page 0
// R17: page select locked until key unlocks
// R18: key C5 allows one change, then clears
// R19: key readable, writable, resets to zero
// R20: mask write-only reset zero; status read-only
// R21: software selects page before page writes
// R22: idle bus leaves data line high
// R23: locked page write acknowledged, page unchanged
`timescale 1ns/1ps
`default_nettype none
`include "pirp_cfg.svh"
module pirp_dev
  import pirp_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  pirp_if.dev        bus,
  input  wire logic [1:0] strap_code,
  input  wire logic [7:0] int_status,
  input  wire logic [7:0] page_rd_data,
  output logic      [7:0] page_sel_r,
  output logic      [7:0] int_mask_r,
  output logic      [7:0] reg_ptr_r,
  output logic            wr_stb_r,
  output logic      [7:0] wr_addr_r,
  output logic      [7:0] wr_data_r
);
  pirp_dst_t  st_r;
  pirp_kind_t kind_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] key_r;
  logic       rw_r;
  logic       nack_r;
  logic       sda_oe_r;
  logic       scl_s, sda_s, scl_q, sda_q;
  logic [1:0] strap_s;
  logic [1:0] strap_cnt_r;
  logic [3:0] addr_lo_r;

  // Pin synchronisers
  pirp_sync #(.W(2), .INIT(2'h3)) u_pins (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({bus.scl, bus.sda}),
    .q       ({scl_s, sda_s})
  );
  pirp_sync #(.W(2), .INIT(2'h0)) u_strap (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (strap_code),
    .q       (strap_s)
  );

  // R2: strap decode to low address bits
  function automatic logic [3:0] strap_low(input logic [1:0] c);
    case (c)
      `PIRP_STRAP_GND: strap_low = `PIRP_LO_GND;
      `PIRP_STRAP_VCC: strap_low = `PIRP_LO_VCC;
      // R3: strap on clock or data line
      `PIRP_STRAP_SCL: strap_low = `PIRP_LO_SCL;
      default:         strap_low = `PIRP_LO_SDA;
    endcase
  endfunction : strap_low

  // R12: readable locations of paged space
  function automatic logic paged_readable(input logic [7:0] pg, input logic [7:0] a);
    paged_readable = (pg == `PIRP_PAGE_LED &&
                      ((a >= `PIRP_P0_LO_A && a <= `PIRP_P0_HI_A) ||
                       (a >= `PIRP_P0_LO_B && a <= `PIRP_P0_HI_B))) ||
                     (pg == `PIRP_PAGE_FUNC && a == `PIRP_P3_RD);
  endfunction : paged_readable

  // Bus events from synchronised pins
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  // R4: START detect
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  // R5: STOP detect
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_end  = (st_r == DS_RX) && scl_fall && (cnt_r == 4'h8);
  // R2: own address compare
  wire addr_hit  = (sh_r[7:1] == {`PIRP_ADDR_HI, addr_lo_r});
  wire data_wr   = byte_end && (kind_r == BK_DATA);
  wire is_page   = (reg_ptr_r == `PIRP_OFF_PAGE);
  wire is_key    = (reg_ptr_r == `PIRP_OFF_KEY);
  wire is_mask   = (reg_ptr_r == `PIRP_OFF_MASK);
  wire is_stat   = (reg_ptr_r == `PIRP_OFF_STATUS);
  // R17: page select open only with key
  wire unlocked  = (key_r == `PIRP_KEY_OPEN);
  // R12: read data selection, others read zero
  wire [7:0] rd_byte = is_key  ? key_r :
                       is_stat ? int_status :
                       paged_readable(page_sel_r, reg_ptr_r) ? page_rd_data : 8'h00;

  assign bus.dev_sda_oe = sda_oe_r;

  // Pin history; strap retaken until synchroniser shows the pin, not INIT
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      strap_cnt_r  <= 2'h0;
      addr_lo_r    <= `PIRP_LO_GND;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        addr_lo_r   <= strap_low(strap_s);
      end
    end
  end

  // Register file: key, page select, mask, outward writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // R16: page 0 after reset; R19: key locked
      page_sel_r <= `PIRP_PAGE_RST;
      key_r      <= `PIRP_KEY_RST;
      // R20: mask resets to zero
      int_mask_r <= `PIRP_MASK_RST;
      wr_stb_r   <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_data_r  <= 8'h00;
    end else begin
      // R10: outward store of paged data
      wr_stb_r <= data_wr && !(is_page || is_key || is_mask || is_stat);
      if (data_wr) begin
        wr_addr_r <= reg_ptr_r;
        wr_data_r <= sh_r;
      end
      // R19: key register write
      if (data_wr && is_key) begin
        key_r <= sh_r;
      // R18: one change then key clears
      end else if (data_wr && is_page && unlocked) begin
        key_r <= `PIRP_KEY_RST;
      end
      // R15: page value stored; R23: locked write ignored
      if (data_wr && is_page && unlocked) begin
        page_sel_r <= sh_r;
      end
      // R20: mask write-only
      if (data_wr && is_mask) begin
        int_mask_r <= sh_r;
      end
    end
  end

  // Serial state machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r      <= DS_IDLE;
      kind_r    <= BK_ADDR;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      reg_ptr_r <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else if (stop_det) begin
      // R5: STOP ends transfer
      st_r     <= DS_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      // R4: START, also repeated START
      st_r     <= DS_RX;
      kind_r   <= BK_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        DS_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            // R6: sample MSB first on clock high
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            if (kind_r == BK_ADDR && !addr_hit) begin
              st_r <= DS_IDLE;
            end else begin
              // R7: pull low through acknowledge
              sda_oe_r <= 1'b1;
              st_r     <= DS_ACK;
            end
            // R1: direction bit
            if (kind_r == BK_ADDR) begin
              rw_r <= sh_r[0];
            end
            // R9: register address byte
            if (kind_r == BK_REG) begin
              reg_ptr_r <= sh_r;
            end
            // R11: pointer steps per data byte
            if (kind_r == BK_DATA) begin
              reg_ptr_r <= reg_ptr_r + 8'h01;
            end
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (rw_r && kind_r == BK_ADDR) begin
              // R13: read answer after read address
              sh_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              st_r     <= DS_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r     <= DS_RX;
              kind_r   <= (kind_r == BK_ADDR) ? BK_REG : BK_DATA;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              sda_oe_r <= 1'b0;
              st_r     <= DS_MACK;
            end else begin
              // R6: next bit, MSB first
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
              cnt_r    <= cnt_r + 4'h1;
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
            if (!sda_s) begin
              reg_ptr_r <= reg_ptr_r + 8'h01;
            end
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (nack_r) begin
              st_r <= DS_IDLE;
            end else begin
              sh_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              st_r     <= DS_TX;
            end
          end
        end
        DS_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          st_r     <= DS_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end
endmodule : pirp_dev
`default_nettype wire

// ===== rtl/pirp_host.sv
/*
  Host end of the paged two-wire register port: issues one-byte register
  writes and reads with repeated start. Software drives it through a
  plain command port with read data one cycle after the read strobe.
  Assumes the device end answers on the shared interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pirp_cfg.svh"
module pirp_host
  import pirp_pkg::*;
#(
  parameter int QTR = (`PIRP_SCL_NS + 4 * `PIRP_CLK_NS - 1) / (4 * `PIRP_CLK_NS)
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  pirp_if.host            bus,
  input  wire logic [2:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  output logic      [7:0] cpu_rdata_r
);
  pirp_hst_t  st_r;
  logic [1:0] ph_r;
  logic [1:0] seq_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [6:0] tgt_r;
  logic [7:0] reg_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic       rd_mode_r;
  logic       ack_bit_r;
  logic       nack_r;
  logic       scl_r;
  logic       sda_oe_r;
  logic       sda_s;
  logic [15:0] div_r;

  pirp_sync #(.W(1), .INIT(1'b1)) u_sda (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (bus.sda),
    .q       (sda_s)
  );

  // R1: direction bit appended to target address
  function automatic logic [7:0] byte_for(input logic [1:0] s, input logic rd,
                                          input logic [6:0] t, input logic [7:0] r,
                                          input logic [7:0] w);
    case (s)
      2'h0:    byte_for = {t, 1'b0};
      2'h1:    byte_for = r;
      default: byte_for = rd ? {t, 1'b1} : w;
    endcase
  endfunction : byte_for

  wire       busy    = (st_r != HS_IDLE);
  wire       tick    = (div_r == 16'(QTR - 1));
  wire       go      = cpu_wr && !busy && (cpu_addr == `PIRP_H_CMD) &&
                       (cpu_wdata[`PIRP_CMD_WR] || cpu_wdata[`PIRP_CMD_RD]);
  wire       rx_byte = rd_mode_r && (seq_r == 2'h3);
  wire [1:0] seq_inc = seq_r + 2'h1;
  wire [7:0] next_tx = byte_for(seq_inc, rd_mode_r, tgt_r, reg_r, wdata_r);
  wire [7:0] rd_mux  = (cpu_addr == `PIRP_H_TGT)   ? {1'b0, tgt_r} :
                       (cpu_addr == `PIRP_H_REG)   ? reg_r :
                       (cpu_addr == `PIRP_H_WDATA) ? wdata_r :
                       (cpu_addr == `PIRP_H_CMD)   ? {6'h00, nack_r, busy} :
                       (cpu_addr == `PIRP_H_RDATA) ? rdata_r : 8'h00;

  assign bus.scl         = scl_r;
  assign bus.host_sda_oe = sda_oe_r;

  // Quarter-bit divider, runs only while busy
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !busy || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Command port registers and read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tgt_r       <= `PIRP_H_TGT_RST;
      reg_r       <= 8'h00;
      wdata_r     <= 8'h00;
      cpu_rdata_r <= 8'h00;
    end else begin
      cpu_rdata_r <= cpu_rd ? rd_mux : 8'h00;
      // R14, R21: page choice is software's own write sequence
      if (cpu_wr && !busy && cpu_addr == `PIRP_H_TGT) begin
        tgt_r <= cpu_wdata[6:0];
      end
      if (cpu_wr && !busy && cpu_addr == `PIRP_H_REG) begin
        reg_r <= cpu_wdata;
      end
      if (cpu_wr && !busy && cpu_addr == `PIRP_H_WDATA) begin
        wdata_r <= cpu_wdata;
      end
    end
  end

  // Bus sequencer, four quarter phases per bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r      <= HS_IDLE;
      ph_r      <= 2'h0;
      seq_r     <= 2'h0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      rdata_r   <= 8'h00;
      rd_mode_r <= 1'b0;
      ack_bit_r <= 1'b1;
      nack_r    <= 1'b0;
      // R22: idle bus, data released high
      scl_r     <= 1'b1;
      sda_oe_r  <= 1'b0;
    end else if (go) begin
      st_r      <= HS_START;
      ph_r      <= 2'h0;
      seq_r     <= 2'h0;
      nack_r    <= 1'b0;
      rd_mode_r <= cpu_wdata[`PIRP_CMD_RD];
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      case (st_r)
        HS_START: begin
          // R4: data falls while clock high
          case (ph_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_r    <= 1'b1;
            2'h2: sda_oe_r <= 1'b1;
            default: begin
              scl_r <= 1'b0;
              sh_r  <= byte_for(seq_r, rd_mode_r, tgt_r, reg_r, wdata_r);
              bit_r <= 4'h0;
              st_r  <= HS_BIT;
            end
          endcase
        end
        HS_BIT: begin
          case (ph_r)
            // R6: bit set while clock low, MSB first
            2'h0: sda_oe_r <= (bit_r != 4'h8) && !rx_byte && !sh_r[7];
            2'h1: scl_r    <= 1'b1;
            2'h2: begin
              if (bit_r != 4'h8) begin
                sh_r <= {sh_r[6:0], sda_s};
              end else begin
                ack_bit_r <= sda_s;
              end
            end
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                bit_r <= 4'h0;
                if (!rx_byte && ack_bit_r) begin
                  // R8: no acknowledge, stop and abandon
                  nack_r <= 1'b1;
                  st_r   <= HS_STOP;
                end else if (rx_byte) begin
                  rdata_r <= sh_r;
                  st_r    <= HS_STOP;
                end else if (!rd_mode_r && seq_r == 2'h2) begin
                  st_r <= HS_STOP;
                end else if (rd_mode_r && seq_r == 2'h1) begin
                  // R13: repeated START before read address
                  seq_r <= 2'h2;
                  st_r  <= HS_START;
                end else begin
                  // R9: register address follows address byte
                  seq_r <= seq_inc;
                  sh_r  <= next_tx;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          // R5: data rises while clock high
          case (ph_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_r    <= 1'b1;
            2'h2: sda_oe_r <= 1'b0;
            default: st_r  <= HS_IDLE;
          endcase
        end
        HS_IDLE: begin
          scl_r    <= 1'b1;
          sda_oe_r <= 1'b0;
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
endmodule : pirp_host
`default_nettype wire

// ===== sim/pirp_link_properties.sv
/*
  Checker of the two-wire link between host end and device end.
  Assumes it sits beside the interface, on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pirp_link_properties #(
  parameter int QTR = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  localparam int SLIM = 4 * QTR;
  logic       scl_q;
  logic       sda_q;
  logic       busy_r;
  logic [3:0] bit_r;
  // Line events at the system clock
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev  = scl & scl_q & ~sda_q & sda;
  wire rise_ev  = scl & ~scl_q;
  // Edge history, transfer flag, clock pulses modulo nine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_r <= 1'b0;
      bit_r  <= 4'h0;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      busy_r <= start_ev | (busy_r & ~stop_ev);
      if (start_ev)
        bit_r <= 4'h0;
      else if (rise_ev)
        bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence start_s;
    start_ev;
  endsequence
  sequence stop_s;
    stop_ev;
  endsequence
  sequence frame_end_s;
    stop_ev || (start_ev && busy_r);
  endsequence
  // Link checks
  idle_data_high_a: assert property (!busy_r |-> sda || start_ev)
    else $error("data line low while idle");
  idle_clock_high_a: assert property (!busy_r |-> scl)
    else $error("clock low while idle");
  dev_idle_quiet_a: assert property (!busy_r |-> !dev_sda_oe)
    else $error("device drives outside a transfer");
  dev_high_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device changed data while clock high");
  ack_host_free_a: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("host drives during device bit");
  frame_bits_a: assert property (frame_end_s |-> bit_r == 4'h1)
    else $error("frame not whole bytes plus acknowledge");
  start_clock_low_a: assert property (start_s |-> ##[1:SLIM] !scl)
    else $error("clock not lowered after start");
  stop_idle_hold_a: assert property (stop_s |=> (scl && sda) [*8])
    else $error("bus not idle after stop");
endmodule : pirp_link_properties
`default_nettype wire

// ===== sim/tb_top.sv
/*
  Testbench of the paged two-wire register port, both ends joined.
  Assumes the link checker; constants are written out, not taken from the header.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int QTR = 2;
  logic       clk_sys;
  logic       rst_n;
  logic [1:0] strap_code;
  logic [7:0] int_status;
  logic [7:0] pg_base;
  wire  [7:0] page_rd_data;
  logic [7:0] page_sel_r;
  logic [7:0] int_mask_r;
  logic [7:0] reg_ptr_r;
  logic       wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [2:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic       cpu_wr;
  logic       cpu_rd;
  logic [7:0] cpu_rdata_r;
  logic [6:0] tgt;
  logic       nk;
  logic [7:0] q, r, d, key_m, st_a, st_d;
  int         fail_count, checks_done, cyc, st_n, n, i, j;
  logic [7:0] rtab [9] = '{8'h18, 8'h2D, 8'h2E, 8'h30, 8'h45, 8'h46, 8'h11, 8'hF0, 8'hF1};

  pirp_if u_pirp_if ();
  pirp_host #(.QTR(QTR)) u_pirp_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(u_pirp_if.host), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_r(cpu_rdata_r));
  pirp_dev u_pirp_dev (.clk_sys(clk_sys), .rst_n(rst_n), .bus(u_pirp_if.dev),
    .strap_code(strap_code), .int_status(int_status), .page_rd_data(page_rd_data),
    .page_sel_r(page_sel_r), .int_mask_r(int_mask_r), .reg_ptr_r(reg_ptr_r),
    .wr_stb_r(wr_stb_r), .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r));
  pirp_link_properties #(.QTR(QTR)) u_pirp_link_properties (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl(u_pirp_if.scl), .host_sda_oe(u_pirp_if.host_sda_oe),
    .dev_sda_oe(u_pirp_if.dev_sda_oe), .sda(u_pirp_if.sda));

  // Paged contents follow register pointer
  assign page_rd_data = pg_base ^ reg_ptr_r;
  // Clock
  always #4 clk_sys = ~clk_sys;
  // Hang guard and capture of paged write pulses
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wr_stb_r === 1'b1) begin
      st_n <= st_n + 1;
      st_a <= wr_addr_r;
      st_d <= wr_data_r;
    end
    if (cyc == 80000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  function automatic logic [6:0] exp_tgt(input logic [1:0] s);
    return {3'h5, s == 2'h0 ? 4'h0 : s == 2'h1 ? 4'hF : s == 2'h2 ? 4'h5 : 4'hA};
  endfunction : exp_tgt

  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] pg);
    if (a == 8'hFE) return key_m;
    if (a == 8'hF1) return int_status;
    if (pg == 8'h00 && ((a >= 8'h18 && a <= 8'h2D) || (a >= 8'h30 && a <= 8'h45)))
      return pg_base ^ a;
    if (pg == 8'h03 && a == 8'h11) return pg_base ^ a;
    return 8'h00;
  endfunction : exp_rd

  task automatic reset_dut(input logic [1:0] s);
    @(posedge clk_sys);
    rst_n      <= 1'b0;
    strap_code <= s;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : reset_dut

  task automatic cw(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    cpu_addr  <= a;
    cpu_wdata <= v;
    cpu_wr    <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask : cw

  task automatic cr(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1 v = cpu_rdata_r;
  endtask : cr

  task automatic xfer(input logic [7:0] ra, input logic [7:0] wd, input logic rdn,
                      output logic ak, output logic [7:0] rv);
    logic [7:0] s;
    int         k;
    cw(3'h0, {1'b0, tgt});
    cw(3'h1, ra);
    cw(3'h2, wd);
    cw(3'h3, rdn ? 8'h02 : 8'h01);
    s = 8'h01;
    for (k = 0; k < 2000 && s[0] !== 1'b0; k++) cr(3'h3, s);
    chk({7'h00, s[0]}, 8'h00, "transfer hung");
    ak = s[1];
    cr(3'h4, rv);
  endtask : xfer

  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    xfer(ra, wd, 1'b0, nk, q);
    chk({7'h00, nk}, 8'h00, "write refused");
  endtask : wr

  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    xfer(ra, 8'h00, 1'b1, nk, q);
    chk({7'h00, nk}, 8'h00, "read refused");
    chk(q, e, "read data");
  endtask : rd

  initial begin
    clk_sys    = 1'b0;
    rst_n      = 1'b0;
    strap_code = 2'h0;
    int_status = 8'h00;
    pg_base    = 8'h00;
    cpu_addr   = 3'h0;
    cpu_wdata  = 8'h00;
    cpu_wr     = 1'b0;
    cpu_rd     = 1'b0;
    {fail_count, checks_done, cyc, st_n} = '0;
    key_m = 8'h00;
    n = $urandom(15);
    // Every strap: own address answered, neighbour refused
    for (i = 0; i < 4; i++) begin
      reset_dut(i[1:0]);
      chk(page_sel_r, 8'h00, "page reset");
      chk(int_mask_r, 8'h00, "mask reset");
      tgt = exp_tgt(i[1:0]);
      rd(8'hFE, 8'h00);
      tgt = tgt ^ 7'h01;
      xfer(8'hFE, 8'hC5, 1'b0, nk, q);
      chk({7'h00, nk}, 8'h01, "wrong address acked");
      tgt = tgt ^ 7'h01;
    end
    // Locked page select, key, one change only
    wr(8'hFD, 8'($urandom_range(3, 1)));
    chk(page_sel_r, 8'h00, "locked page");
    wr(8'hFE, 8'hC5);
    key_m = 8'hC5;
    rd(8'hFE, key_m);
    wr(8'hFD, 8'h03);
    key_m = 8'h00;
    chk(page_sel_r, 8'h03, "page opened");
    rd(8'hFE, key_m);
    wr(8'hFD, 8'h01);
    chk(page_sel_r, 8'h03, "second change");
    // Every page, then the readable windows
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      int_status <= 8'($urandom);
      pg_base    <= 8'($urandom);
      wr(8'hFE, 8'hC5);
      wr(8'hFD, i[7:0]);
      chk(page_sel_r, i[7:0], "page value");
      for (j = 0; j < 10; j++) begin
        r = (j < 9) ? rtab[j] : 8'($urandom);
        rd(r, exp_rd(r, i[7:0]));
      end
    end
    // Paged stores, pointer step, mask register
    for (j = 0; j < 6; j++) begin
      r = 8'($urandom_range(8'hEF, 0));
      d = 8'($urandom);
      n = st_n;
      wr(r, d);
      chk(st_a, r, "store address");
      chk(st_d, d, "store data");
      chk(8'(st_n - n), 8'h01, "store count");
      chk(reg_ptr_r, r + 8'h01, "pointer step");
      wr(8'hF0, d ^ 8'hA5);
      chk(int_mask_r, d ^ 8'hA5, "mask value");
      chk(8'(st_n - n), 8'h01, "mask stored as paged");
    end
    // Mid-run reset clears page, mask and a pending key
    wr(8'hFE, 8'hC5);
    reset_dut(2'h3);
    chk(page_sel_r, 8'h00, "page after reset");
    chk(int_mask_r, 8'h00, "mask after reset");
    rd(8'hFE, 8'h00);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
